// ### rtl/reload_down_timer_16bit.sv
// two-channel 16-bit reload down-timer with apb register access
// assumes asynchronous pin inputs and a master that honours pready
`include "reload_timer_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module reload_down_timer_16bit (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // timer pins and service
    input  wire logic [1:0]  ext_in_pin_i,
    input  wire logic [1:0]  iio_clear_i,
    output logic      [1:0]  timer_out_pin_o,
    output logic      [1:0]  pin_drive_en_o,
    output logic      [1:0]  irq_o
);
    import reload_timer_pkg::*;

    // bus decode
    logic        acc;
    logic        wr;
    logic        ch_sel;
    logic [1:0]  reg_sel;
    logic        mapped;
    logic        pready_q;

    // per-channel state seen by the read mux
    tmr_cfg_s    cfg_q    [2];
    tmr_state_e  state_q  [2];
    logic        uf_q     [2];
    logic [15:0] cnt_q    [2];
    logic [15:0] rld_q    [2];

    assign acc     = psel_i & penable_i;
    assign wr      = acc & pready_q & pwrite_i;
    assign ch_sel  = paddr_i[`TMR_CH_BIT];
    assign reg_sel = paddr_i[3:2];
    // only two channels of three words each are decoded
    assign mapped  = (paddr_i[11:5] == 7'h00) & (paddr_i[1:0] == 2'h0)
                   & (reg_sel != 2'h3);

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= acc & ~pready_q;
        end
    end

    // error flag rides with pready for unmapped words
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= acc & ~pready_q & ~mapped;
        end
    end

    // read data captured together with pready
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (acc & ~pready_q & ~pwrite_i & mapped) begin
            case (reg_sel)
                `TMR_OFF_CTRL: begin
                    prdata_o <= {16'h0000, 4'h0,
                        cfg_q[ch_sel].clk_src,
                        cfg_q[ch_sel].gate_select,
                        cfg_q[ch_sel].edge_sel,
                        cfg_q[ch_sel].pin_drive_en,
                        cfg_q[ch_sel].pin_polarity,
                        cfg_q[ch_sel].auto_reload_en,
                        cfg_q[ch_sel].irq_enable,
                        uf_q[ch_sel],
                        state_q[ch_sel] != ST_STOP,
                        1'b0};
                end
                `TMR_OFF_COUNT: begin
                    prdata_o <= {16'h0000, cnt_q[ch_sel]};
                end
                `TMR_OFF_RELOAD: begin
                    prdata_o <= {16'h0000, rld_q[ch_sel]};
                end
                default: begin
                    prdata_o <= 32'h0000_0000;
                end
            endcase
        end else begin
            prdata_o <= 32'h0000_0000;
        end
    end

    assign pready_o = pready_q;

    // one identical channel per timer
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ch
            tmr_wr_s    w;
            logic [2:0] sync_q;
            logic       pin_now;
            logic       rise;
            logic       fall;
            logic       edge_hit;
            logic       ext_mode;
            logic       trig;
            logic       load_q;
            logic [4:0] pre_q;
            logic [4:0] mask;
            logic       tick;
            logic       gate_ok;
            logic       count;
            logic       uf_ev;
            logic       tog_q;

            // register strobes for this channel
            assign w.ctrl   = wr & mapped & (ch_sel == 1'(i))
                            & (reg_sel == `TMR_OFF_CTRL);
            assign w.reload = wr & mapped & (ch_sel == 1'(i))
                            & (reg_sel == `TMR_OFF_RELOAD);
            assign w.data   = pwdata_i[15:0];

            // two-stage synchroniser, third stage for edges
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    sync_q <= 3'h0;
                end else begin
                    sync_q <= {sync_q[1:0], ext_in_pin_i[i]};
                end
            end

            assign pin_now = sync_q[1];
            assign rise    = sync_q[1] & ~sync_q[2];
            assign fall    = ~sync_q[1] & sync_q[2];

            // selected edge, shared by trigger and event modes
            always_comb begin
                case (cfg_q[i].edge_sel)
                    2'h1:    edge_hit = rise;
                    2'h2:    edge_hit = fall;
                    2'h3:    edge_hit = rise | fall;
                    default: edge_hit = 1'b0;
                endcase
            end

            assign ext_mode = cfg_q[i].clk_src == 2'h3;

            // soft trigger may come with the enable in the same write
            assign trig = (w.ctrl & w.data[`TMR_B_TRG]
                          & w.data[`TMR_B_CE])
                        | (~ext_mode & ~cfg_q[i].gate_select
                          & edge_hit & (state_q[i] != ST_STOP));

            // load follows the trigger by one clock
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    load_q <= 1'b0;
                end else begin
                    load_q <= trig;
                end
            end

            // prescaler tap for the internal clock
            always_comb begin
                case (cfg_q[i].clk_src)
                    2'h0:    mask = `TMR_PRE_DIV2;
                    2'h1:    mask = `TMR_PRE_DIV8;
                    default: mask = `TMR_PRE_DIV32;
                endcase
            end

            // free running, cleared on a start so the first
            // count clock has its full period
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    pre_q <= 5'h00;
                end else if (load_q) begin
                    pre_q <= 5'h00;
                end else begin
                    pre_q <= pre_q + 5'h01;
                end
            end

            assign tick    = ext_mode ? edge_hit
                                      : ((pre_q & mask) == mask);
            assign gate_ok = ext_mode | ~cfg_q[i].gate_select
                           | (pin_now == cfg_q[i].edge_sel[0]);
            assign count   = (state_q[i] == ST_RUN) & tick
                           & gate_ok & ~load_q;
            assign uf_ev   = count & (cnt_q[i] == 16'h0000);

            // stop, wait and run
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    state_q[i] <= ST_STOP;
                end else if (w.ctrl & ~w.data[`TMR_B_CE]) begin
                    state_q[i] <= ST_STOP;
                end else if (load_q & (state_q[i] != ST_STOP)) begin
                    state_q[i] <= ST_RUN;
                end else if (w.ctrl & (state_q[i] == ST_STOP)) begin
                    state_q[i] <= ST_WAIT;
                end else if (uf_ev & ~cfg_q[i].auto_reload_en) begin
                    state_q[i] <= ST_WAIT;
                end
            end

            // down counter
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    cnt_q[i] <= `TMR_COUNT_RST;
                end else if (load_q & (state_q[i] != ST_STOP)) begin
                    cnt_q[i] <= rld_q[i];
                end else if (uf_ev) begin
                    cnt_q[i] <= cfg_q[i].auto_reload_en
                              ? rld_q[i]
                              : `TMR_UF_VALUE;
                end else if (count) begin
                    cnt_q[i] <= cnt_q[i] - 16'h0001;
                end
            end

            // reload value, whole word per write
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    rld_q[i] <= `TMR_RELOAD_RST;
                end else if (w.reload) begin
                    rld_q[i] <= w.data;
                end
            end

            // configuration; meant to change only while stopped
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    cfg_q[i] <= tmr_cfg_s'(9'h000);
                end else if (w.ctrl) begin
                    cfg_q[i] <= w.data[11:3];
                end
            end

            // sticky flag: a new underflow beats any clear
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    uf_q[i] <= 1'b0;
                end else if (uf_ev) begin
                    uf_q[i] <= 1'b1;
                end else if ((w.ctrl & ~w.data[`TMR_B_UF])
                             | iio_clear_i[i]) begin
                    uf_q[i] <= 1'b0;
                end
            end

            // toggle level starts at polarity on each start
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    tog_q <= 1'b0;
                end else if (load_q & (state_q[i] != ST_STOP)) begin
                    tog_q <= cfg_q[i].pin_polarity;
                end else if (uf_ev & cfg_q[i].auto_reload_en) begin
                    tog_q <= ~tog_q;
                end
            end

            // pin waveform, select and interrupt all registered
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    timer_out_pin_o[i] <= 1'b0;
                    pin_drive_en_o[i]  <= 1'b0;
                    irq_o[i]           <= 1'b0;
                end else begin
                    timer_out_pin_o[i] <= cfg_q[i].auto_reload_en
                        ? tog_q
                        : ((state_q[i] == ST_RUN)
                           ^ cfg_q[i].pin_polarity);
                    pin_drive_en_o[i]  <= cfg_q[i].pin_drive_en;
                    irq_o[i] <= uf_q[i] & cfg_q[i].irq_enable;
                end
            end
        end
    endgenerate

endmodule : reload_down_timer_16bit

`default_nettype wire

// ### rtl/reload_timer_regs.svh
// register map, field positions, reset values and counts of the timer
// assumes byte addresses on a 32-bit apb, one word per register
`ifndef RELOAD_TIMER_REGS_SVH
`define RELOAD_TIMER_REGS_SVH

// word offsets inside one channel, channel select bit in the address
`define TMR_OFF_CTRL     2'h0
`define TMR_OFF_COUNT    2'h1
`define TMR_OFF_RELOAD   2'h2
`define TMR_CH_BIT       4
`define TMR_ADDR_W       12

// control and status field positions
`define TMR_B_TRG        0
`define TMR_B_CE         1
`define TMR_B_UF         2
`define TMR_B_IE         3
`define TMR_B_AUTO_RELOAD_EN       4
`define TMR_B_POL        5
`define TMR_B_DRV        6
`define TMR_B_EDGE_LO    7
`define TMR_B_EDGE_HI    8
`define TMR_B_GATE       9
`define TMR_B_CLK_LO     10
`define TMR_B_CLK_HI     11

// reset values and the count left by a one-shot underflow
`define TMR_CTRL_RST     16'h0000
`define TMR_COUNT_RST    16'h0000
`define TMR_RELOAD_RST   16'h0000
`define TMR_UF_VALUE     16'hFFFF

// prescaler tap masks: divide by 2, 8 and 32
`define TMR_PRE_DIV2     5'h01
`define TMR_PRE_DIV8     5'h07
`define TMR_PRE_DIV32    5'h1F

// cycles from a start trigger to the counter load
`define TMR_LOAD_CYC     1

`endif

// ### rtl/reload_timer_pkg.sv
// types shared by the reload timer
// assumes the constants header is included by the design file
package reload_timer_pkg;

    // counter state: stopped, waiting for trigger, running
    typedef enum logic [1:0] {
        ST_STOP = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN  = 2'b10
    } tmr_state_e;

    // writable configuration of one channel
    typedef struct packed {
        logic [1:0] clk_src;
        logic       gate_select;
        logic [1:0] edge_sel;
        logic       pin_drive_en;
        logic       pin_polarity;
        logic       auto_reload_en;
        logic       irq_enable;
    } tmr_cfg_s;

    // one decoded apb register write
    typedef struct packed {
        logic       ctrl;
        logic       reload;
        logic [15:0] data;
    } tmr_wr_s;

endpackage : reload_timer_pkg

// ### testbench/reload_timer_sva.sv
// checker for the timer's bus answers and pin outputs
// assumes it is bound to the timer's top module, one clock domain
`timescale 1ns/10ps
`default_nettype none
module reload_timer_sva (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rstn_i,
    // apb side
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // pins
    input wire logic [1:0]  timer_out_pin_o,
    input wire logic [1:0]  pin_drive_en_o,
    input wire logic [1:0]  irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // access phase opens, then exactly one wait state
    sequence acc_start; $rose(penable_i) && psel_i; endsequence
    sequence one_wait; !pready_o ##1 pready_o; endsequence
    sequence ctrl_wr; pready_o && pwrite_i && paddr_i == 12'h000;
    endsequence
    apb_wait_a: assert property (acc_start |-> one_wait)
        else $error("apb answer not after one wait state");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside answer cycle");
    bad_addr_a: assert property (pready_o && paddr_i[11:5] != 7'h00
        |-> pslverr_o && prdata_o == 32'h0) else $error("no error");
    trg_read0_a: assert property (pready_o && !pwrite_i
        && paddr_i == 12'h000 |-> prdata_o[0] == 1'b0)
        else $error("trigger bit read as one");
    drive_copy_a: assert property (ctrl_wr |-> ##2
        pin_drive_en_o[0] == $past(pwdata_i[6], 2))
        else $error("pin drive enable not following write");
    irq_mask_a: assert property (ctrl_wr and !pwdata_i[3]
        |-> ##2 !irq_o[0]) else $error("irq with enable clear");
    reset_quiet_a: assert property ($rose(rstn_i) |-> irq_o == 2'h0
        && timer_out_pin_o == 2'h0 && pin_drive_en_o == 2'h0)
        else $error("outputs active after reset");
endmodule : reload_timer_sva

bind reload_down_timer_16bit reload_timer_sva reload_timer_sva_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .timer_out_pin_o(timer_out_pin_o),
    .pin_drive_en_o(pin_drive_en_o), .irq_o(irq_o));
`default_nettype wire

// ### testbench/ext_pin_model.sv
// source of the two timer input pins, as trigger, gate or event
// assumes the bench asks for levels; each level is held 4 cycles
`timescale 1ns/10ps
`default_nettype none
module ext_pin_model (
    // clock
    input wire logic       clk_i,
    // requested and driven levels
    input wire logic [1:0] level_i,
    output logic     [1:0] pin_o
);
    logic [2:0] hold_q;
    // a new level waits out the hold, so narrow pulses never leave here
    always @(posedge clk_i) begin
        if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end else if (level_i != pin_o) begin
            pin_o  <= level_i;
            hold_q <= 3'h3;
        end
    end
    initial pin_o = 2'h0;
    initial hold_q = 3'h0;
endmodule : ext_pin_model
`default_nettype wire

// ### testbench/reload_down_timer_16bit_tb_top.sv
// self-checking bench for the two-channel reload down-timer
// assumes a 250 MHz clock and the one-wait-state apb answer
`timescale 1ns/10ps
`default_nettype none
module reload_down_timer_16bit_tb_top;
    import reload_timer_pkg::*;
    // stimulus and observed signals
    logic clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, rdat;
    logic        pready_o, pslverr_o, rerr;
    logic [1:0]  lvl = 0, pin, iio_clear_i = 0, tout, drv, irq_o;
    int          num_errors = 0, total_checks = 0;
    always #2 clk_i = ~clk_i;
    reload_down_timer_16bit reload_down_timer_16bit_inst (.clk_i(clk_i),
        .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .ext_in_pin_i(pin), .iio_clear_i(iio_clear_i),
        .timer_out_pin_o(tout), .pin_drive_en_o(drv), .irq_o(irq_o));
    ext_pin_model ext_pin_model_inst (.clk_i(clk_i), .level_i(lvl),
        .pin_o(pin));
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        do begin @(posedge clk_i); n++; end while (pready_o !== 1 && n < 20);
        rdat = prdata_o; rerr = pslverr_o;
        psel_i <= 0; penable_i <= 0;
    endtask : apb
    task automatic wt(input int n); repeat (n) @(posedge clk_i); endtask : wt
    // soft trigger, one-shot underflow, flag, irq and bus refusal
    task automatic t_soft();
        apb(0, 12'h000, 0); chk("ctrl rst", rdat, 32'h0);
        apb(0, 12'h00C, 0); chk("unmapped", rdat, 32'h0);
        chk("unmapped err", rerr, 1'b1);
        apb(1, 12'h008, 32'h3); apb(1, 12'h000, 32'h1);
        apb(0, 12'h000, 0); chk("trg no ce", rdat, 32'h0);
        apb(1, 12'h000, 32'h4B); wt(3); chk("oneshot hi", tout[0], 1);
        wt(30); apb(0, 12'h000, 0); chk("uf set", rdat, 32'h4E);
        apb(0, 12'h004, 0); chk("stop ffff", rdat, 32'hFFFF);
        chk("irq", irq_o, 2'h1); chk("out idle", tout[0], 0);
        apb(1, 12'h000, 32'h4E); apb(0, 12'h000, 0);
        chk("uf w1", rdat, 32'h4E);
        apb(1, 12'h000, 32'h4A); wt(3); chk("uf w0", irq_o, 2'h0);
        apb(1, 12'h000, 32'h4B); wt(30); iio_clear_i <= 2'h1; wt(1);
        iio_clear_i <= 2'h0; wt(3); chk("iio clr", irq_o, 2'h0);
        apb(1, 12'h000, 32'h0);
    endtask : t_soft
    // reload toggle period for every internal tap on channel 0, divide-by-2 tap only on channel 1
    task automatic t_toggle(input int ch, input int src);
        int n, per;
        logic [11:0] b;
        b = 12'(ch * 16); n = 0; per = (2 << (2 * src)) * 5;
        apb(1, b + 12'h8, 32'h4);
        apb(1, b, 32'h73 | (src << 10)); wt(3);
        chk("tgl hi start", tout[ch], 1);
        while (tout[ch] === 1 && n < 400) begin wt(1); n++; end
        n = 0;
        while (tout[ch] === 0 && n < 400) begin wt(1); n++; end
        chk("tgl period", n, per);
        apb(1, b, 32'h0);
    endtask : t_toggle
    // pin trigger codes: off, rising, falling, both
    task automatic t_pin();
        apb(1, 12'h008, 32'h100);
        for (int c = 0; c < 4; c++) begin
            lvl[0] <= (c == 2); wt(8);
            apb(1, 12'h000, 32'h42 | (c << 7)); wt(8);
            chk("pin wait", tout[0], 0);
            lvl[0] <= (c != 2); wt(10);
            chk("pin trig", tout[0], c != 0);
            apb(1, 12'h000, 32'h0);
        end
    endtask : t_pin
    // gate high-active, then event counting with gate bit ignored
    task automatic t_gate_event();
        logic [31:0] a;
        lvl[0] <= 0; wt(8); apb(1, 12'h000, 32'h283); wt(4);
        apb(0, 12'h004, 0); a = rdat; wt(20); apb(0, 12'h004, 0);
        chk("gate hold", rdat, a);
        lvl[0] <= 1; wt(20); apb(0, 12'h004, 0);
        chk("gate run", rdat < a, 1);
        apb(1, 12'h000, 32'h0); lvl[0] <= 0;
        apb(1, 12'h008, 32'h2); apb(1, 12'h000, 32'hE83);
        repeat (2) begin wt(10); lvl[0] <= 1; wt(10); lvl[0] <= 0; end
        wt(10); apb(0, 12'h000, 0); chk("two events", rdat[2], 0);
        lvl[0] <= 1; wt(12); apb(0, 12'h000, 0);
        chk("third event", rdat[2], 1);
        apb(1, 12'h000, 32'h0);
    endtask : t_gate_event
    initial begin
        wt(20); rstn_i <= 1; wt(4);
        t_soft();
        for (int s = 0; s < 3; s++) t_toggle(0, s);
        t_toggle(1, 0);
        t_pin();
        t_gate_event();
        final_report();
    end
    // watchdog well beyond the thousand or so cycles the run needs
    initial begin
        wt(20000); num_errors++; final_report();
    end
endmodule : reload_down_timer_16bit_tb_top
`default_nettype wire
